// ==== irqf_defs.vh ====
// register offsets, field positions and reset values for the irq flag block
`ifndef IRQF_DEFS_VH
`define IRQF_DEFS_VH

`define IRQF_ADDR_W          16
`define IRQF_OFS_SRC_FIRST   16'h00F4
`define IRQF_OFS_SRC_LAST    16'h00FB
`define IRQF_OFS_RX_FLAGS_A  16'h00F9
`define IRQF_OFS_CHAN_FLAGS  16'h00FA
`define IRQF_OFS_ENABLE_A    16'h0102
`define IRQF_OFS_ENABLE_B    16'h0103
`define IRQF_ENABLE_RESET    8'h00
`define IRQF_FLAG_RESET      8'h00
`define IRQF_UNMAPPED_DATA   8'h00

// rx_event_flags_a bit positions
`define IRQF_A_RX_TIMEOUT    7
`define IRQF_A_RX_LEVEL      6
`define IRQF_A_FRAME_DONE    5
`define IRQF_A_LEN_FILTER    4
`define IRQF_A_RX_BEGIN      3
`define IRQF_A_PREAMBLE      2
`define IRQF_A_CARRIER       1
`define IRQF_A_GAIN          0

// channel_access_event_flags bit positions
`define IRQF_C_RX_LEVEL      7
`define IRQF_C_FRAME_DONE    6
`define IRQF_C_LEN_FILTER    5
`define IRQF_C_RX_BEGIN      4
`define IRQF_C_CHECK_LIMIT   3
`define IRQF_C_CLEAR_CANCEL  2
`define IRQF_C_CHECK_DONE    1
`define IRQF_C_BACKOFF_DONE  0

`endif

// ==== irqf_source_flags.v ====
// interrupt source flag registers five and six with read-to-clear and pin
//
// Summary of operation
// - a flag is set when its event occurs while its enable bit is one.
// - a host read clears only those flag bits that the read returned as one.
// - host writes to the flag registers are ignored; the host clears by reading.
// - flag contents after reset carry no promised value.
// - register five holds rx timeout, rx level, frame done, length filter in 7..4.
// - register five holds rx begin, preamble, carrier, gain settled in 3..0.
// - register six holds rx level, frame done, length filter, rx begin in 7..4.
// - register six holds check limit, clear/cancel, check done, backoff in 3..0.
// - enable bits gate each request onto the interrupt pin and reset to zero.
`timescale 1ns/1ps
`include "irqf_defs.vh"

module irqf_source_flags #(
    parameter ADDR_W = `IRQF_ADDR_W
) (
    input  wire              clk,            // 50 MHz device clock
    input  wire              rst,            // async reset, active high
    input  wire              hostSelectLow,  // serial select, active low
    input  wire              regRdStb,       // one-cycle read strobe
    input  wire              regWrStb,       // one-cycle write strobe
    input  wire [ADDR_W-1:0] regAddr,        // register address
    input  wire [7:0]        regWrData,      // write data
    input  wire [7:0]        rxEventsA,      // pulses for register five
    input  wire [7:0]        chanEvents,     // pulses for register six
    input  wire              otherFlagsActive, // enabled flags of regs 0-4,7
    output reg  [7:0]        regRdData,      // read data, registered
    output reg               regRdValid,     // read data valid pulse
    output reg               irqPinZero      // interrupt pin, active high
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    reg [7:0] rxEventFlagsA_ff;
    reg [7:0] chanAccessFlags_ff;
    reg [7:0] enableA_ff;
    reg [7:0] enableB_ff;

    reg [7:0] nxt_rxEventFlagsA;
    reg [7:0] nxt_chanAccessFlags;
    reg [7:0] nxt_regRdData;
    reg       nxt_irqPin;

    // ------------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------------
    // address match qualified by an accepted strobe
    function hitAddr;
        input              act;
        input [ADDR_W-1:0] a;
        input [ADDR_W-1:0] target;
        begin
            hitAddr = act & (a == target);
        end
    endfunction

    // clear only the ones that this read hands back to the host
    function [7:0] clearSeen;
        input       rdHit;
        input [7:0] cur;
        input [7:0] ret;
        begin
            if (rdHit) begin
                clearSeen = cur & ~ret;
            end else begin
                clearSeen = cur;
            end
        end
    endfunction

    // set wins over a clear in the same cycle; disabled events are dropped
    function [7:0] setEnabled;
        input [7:0] base;
        input [7:0] ev;
        input [7:0] en;
        begin
            setEnabled = base | (ev & en);
        end
    endfunction

    function anyEnabled;
        input [7:0] fl;
        input [7:0] en;
        begin
            anyEnabled = |(fl & en);
        end
    endfunction

    // ------------------------------------------------------------------
    // access decode
    // ------------------------------------------------------------------
    // neighbour source registers read as zero here; their flags arrive
    // only as the otherFlagsActive level
    wire selActive = ~hostSelectLow;
    wire rdAct     = regRdStb & selActive;
    wire wrAct     = regWrStb & selActive;
    wire rdFlagsA  = hitAddr(rdAct, regAddr, `IRQF_OFS_RX_FLAGS_A);
    wire rdChan    = hitAddr(rdAct, regAddr, `IRQF_OFS_CHAN_FLAGS);
    wire wrEnA     = hitAddr(wrAct, regAddr, `IRQF_OFS_ENABLE_A);
    wire wrEnB     = hitAddr(wrAct, regAddr, `IRQF_OFS_ENABLE_B);

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    function [7:0] readMux;
        input [ADDR_W-1:0] a;
        input [7:0]        fa;
        input [7:0]        fc;
        input [7:0]        ea;
        input [7:0]        eb;
        begin
            case (a)
                `IRQF_OFS_RX_FLAGS_A: readMux = fa;
                `IRQF_OFS_CHAN_FLAGS: readMux = fc;
                `IRQF_OFS_ENABLE_A:   readMux = ea;
                `IRQF_OFS_ENABLE_B:   readMux = eb;
                default:              readMux = `IRQF_UNMAPPED_DATA;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------
    // flag update
    // ------------------------------------------------------------------
    // the value returned is the pre-clear value, so only ones seen get
    // cleared; an event in the same cycle wins and is kept for next read
    // writes never reach the flags
    always @* begin
        nxt_rxEventFlagsA = setEnabled(
            clearSeen(rdFlagsA, rxEventFlagsA_ff, rxEventFlagsA_ff),
            rxEventsA, enableA_ff);
    end

    always @* begin
        nxt_chanAccessFlags = setEnabled(
            clearSeen(rdChan, chanAccessFlags_ff, chanAccessFlags_ff),
            chanEvents, enableB_ff);
    end

    // ------------------------------------------------------------------
    // read data select
    // ------------------------------------------------------------------
    always @* begin
        nxt_regRdData = regRdData;
        if (rdAct) begin
            nxt_regRdData = readMux(regAddr, rxEventFlagsA_ff,
                                    chanAccessFlags_ff, enableA_ff,
                                    enableB_ff);
        end
    end

    // ------------------------------------------------------------------
    // interrupt pin select
    // ------------------------------------------------------------------
    // pin stays up across a burst until every enabled flag has gone
    always @* begin
        nxt_irqPin = anyEnabled(nxt_rxEventFlagsA, enableA_ff)
                   | anyEnabled(nxt_chanAccessFlags, enableB_ff)
                   | otherFlagsActive;
    end

    // ------------------------------------------------------------------
    // flag registers
    // ------------------------------------------------------------------
    // flags get a zero reset for simulation hygiene only; nothing may rely
    // on it
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rxEventFlagsA_ff   <= `IRQF_FLAG_RESET;
            chanAccessFlags_ff <= `IRQF_FLAG_RESET;
        end else begin
            rxEventFlagsA_ff   <= nxt_rxEventFlagsA;
            chanAccessFlags_ff <= nxt_chanAccessFlags;
        end
    end

    // ------------------------------------------------------------------
    // enable registers
    // ------------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            enableA_ff <= `IRQF_ENABLE_RESET;
            enableB_ff <= `IRQF_ENABLE_RESET;
        end else begin
            if (wrEnA) begin
                enableA_ff <= regWrData;
            end
            if (wrEnB) begin
                enableB_ff <= regWrData;
            end
        end
    end

    // ------------------------------------------------------------------
    // read port
    // ------------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            regRdData  <= 8'h00;
            regRdValid <= 1'b0;
        end else begin
            regRdData  <= nxt_regRdData;
            regRdValid <= rdAct;
        end
    end

    // ------------------------------------------------------------------
    // interrupt pin
    // ------------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            irqPinZero <= 1'b0;
        end else begin
            irqPinZero <= nxt_irqPin;
        end
    end

endmodule

// ==== irqf_checker.sv ====
// port assertions for the irq source flag block
`timescale 1ns/1ps
module irqf_checker (
    input wire        clk,              // device clock
    input wire        rst,              // async reset, active high
    input wire        hostSelectLow,    // serial select, active low
    input wire        regRdStb,         // read strobe
    input wire        regWrStb,         // write strobe
    input wire [15:0] regAddr,          // register address
    input wire [7:0]  rxEventsA,        // register five event pulses
    input wire [7:0]  chanEvents,       // register six event pulses
    input wire [7:0]  regRdData,        // read data
    input wire        otherFlagsActive, // neighbour flags level
    input wire        regRdValid,       // read data valid pulse
    input wire        irqPinZero        // interrupt pin
);
    wire rd = regRdStb && !hostSelectLow;
    // no event pulse, so a reread must see the clear
    wire q  = rxEventsA == 8'h00 && chanEvents == 8'h00;
    wire rA = rd && q && regAddr == 16'h00F9;
    wire rC = rd && q && regAddr == 16'h00FA;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    rd_answer_a: assert property (rd |=> regRdValid)
        else $error("read not answered");
    valid_cause_a: assert property (regRdValid |-> $past(rd))
        else $error("valid without read");
    wr_silent_a: assert property (regWrStb && !regRdStb |=> !regRdValid)
        else $error("write answered");
    unmapped_a: assert property (rd && regAddr > 16'h0103 |=> !regRdData)
        else $error("unmapped read not zero");
    data_hold_a: assert property (!rd |=> $stable(regRdData))
        else $error("read data moved");
    pin_hold_a: assert property (otherFlagsActive |=> irqPinZero)
        else $error("pin not held");
    clr_five_a: assert property (rA ##1 rA |=> regRdData == 8'h00)
        else $error("flags five not cleared");
    clr_six_a: assert property (rC ##1 rC |=> regRdData == 8'h00)
        else $error("flags six not cleared");
endmodule
bind irqf_source_flags irqf_checker chk_u (.clk, .rst, .hostSelectLow,
    .regRdStb, .regWrStb, .regAddr, .rxEventsA, .chanEvents, .regRdData,
    .otherFlagsActive, .regRdValid, .irqPinZero);

// ==== irqf_host_model.sv ====
// host controller model on the serial register port
`timescale 1ns/1ps
module irqf_host_model (
    input  wire        clk,                   // device clock
    output reg         hostSelectLow = 1'b1,  // select, active low
    output reg         regRdStb = 1'b0,       // read strobe
    output reg         regWrStb = 1'b0,       // write strobe
    output reg  [15:0] regAddr = 16'h0000,    // address
    output reg  [7:0]  regWrData = 8'h00,     // write data
    input  wire [7:0]  regRdData              // read data
);
    reg [7:0] got [0:7];
    integer   i;
    // released lines invert so a stale value cannot pass
    task wr(input [15:0] a, input [7:0] d);
        begin
            @(negedge clk);
            {hostSelectLow, regWrStb, regAddr, regWrData} = {2'b01, a, d};
            @(negedge clk);
            {hostSelectLow, regWrStb, regAddr, regWrData} = {2'b10, ~a, ~d};
        end
    endtask
    // select stays low all eight reads; step 0 rereads one place
    task burst(input [15:0] a, input s);
        begin
            for (i = 0; i < 8; i = i + 1) begin
                @(negedge clk);
                {hostSelectLow, regRdStb} = 2'b01;
                regAddr = a + (s ? i[15:0] : 16'h0000);
                @(posedge clk);
                #1 got[i] = regRdData;
            end
            @(negedge clk);
            {hostSelectLow, regRdStb, regAddr} = {2'b10, ~regAddr};
        end
    endtask
endmodule

// ==== tb_irq_source_flags_rx_cca.sv ====
// random and corner bench for the irq source flag block
`timescale 1ns/1ps
module tb_irq_source_flags_rx_cca;
    reg         clk = 1'b0, rst = 1'b1, go = 1'b0, oth = 1'b0;
    reg  [7:0]  eA, eC, nA, nC;
    wire        sel, rs, ws, pin;
    wire [15:0] ad;
    wire [7:0]  wd, rdt;
    integer     seed = 32'h7604, n_fail = 0, comparisons = 0, t;
    always #10 clk = ~clk;
    irqf_source_flags dut_u (.clk(clk), .rst(rst), .hostSelectLow(sel),
        .regRdStb(rs), .regWrStb(ws), .regAddr(ad), .regWrData(wd),
        .rxEventsA(eA & {8{go}}), .chanEvents(eC & {8{go}}),
        .otherFlagsActive(oth), .regRdData(rdt), .regRdValid(),
        .irqPinZero(pin));
    irqf_host_model host_u (.clk(clk), .hostSelectLow(sel), .regRdStb(rs),
        .regWrStb(ws), .regAddr(ad), .regWrData(wd), .regRdData(rdt));
    task chk(input [7:0] g, input [7:0] e);
        begin
            comparisons = comparisons + 1;
            if (g !== e) begin
                n_fail = n_fail + 1;
                $display("MISMATCH %0t got %h exp %h", $time, g, e);
            end
        end
    endtask
    task finish_test;
        begin
            $display("%0d compares, %0d mismatches", comparisons, n_fail);
            if (n_fail == 0 && comparisons > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    task pulse;
        begin
            @(negedge clk) go = 1'b1;
            @(negedge clk) go = 1'b0;
        end
    endtask
    initial begin
        #100000 n_fail = n_fail + 1;
        finish_test;
    end
    initial begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        host_u.burst(16'h00F4, 1'b1);
        for (t = 0; t < 20; t = t + 1) begin
            {nA, nC, eA, eC} = (t < 2) ? {~{16{t[0]}}, 16'hFFFF}
                                       : $random(seed);
            oth = t[0];
            host_u.wr(16'h0102, nA);
            host_u.wr(16'h0103, nC);
            pulse;
            host_u.wr(16'h00F9, 8'hFF);
            host_u.wr(16'h00FA, 8'hFF);
            chk(pin, |{eA & nA, eC & nC, oth});
            host_u.burst(16'h00F4, 1'b1);
            chk(host_u.got[5], eA & nA);
            chk(host_u.got[6], eC & nC);
            @(negedge clk);
            chk(pin, oth);
            $display("burst test %0d done", t);
        end
        oth = 1'b0;
        host_u.wr(16'h0102, 8'hFF);
        host_u.wr(16'h0103, 8'hFF);
        {eA, eC} = 16'hFFFF;
        for (t = 0; t < 2; t = t + 1) begin
            pulse;
            host_u.burst(16'h00F9 + t[15:0], 1'b0);
            chk(host_u.got[0], 8'hFF);
            chk(host_u.got[1], 8'h00);
        end
        host_u.burst(16'h0200, 1'b1);
        chk(host_u.got[7], 8'h00);
        $display("reread test done");
        finish_test;
    end
endmodule
